// ===== verilog/bctc_pkg.sv
`default_nettype none
package bctc_pkg;
  // ---------------------------------------------------------------
  // Register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SUPPRESS = 8'h04;
  localparam logic [7:0] OFS_STOP     = 8'h08;
  localparam logic [7:0] OFS_DELAY    = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_SEL      = 8'h14;
  localparam logic [7:0] OFS_REC_LO   = 8'h18;
  localparam logic [7:0] OFS_REC_HI   = 8'h1C;
  localparam logic [7:0] OFS_PERF_LO  = 8'h20;
  localparam logic [7:0] OFS_PERF_HI  = 8'h24;
  localparam logic [7:0] OFS_PERF_SEL = 8'h28;
  localparam logic [7:0] OFS_PERF_CNT = 8'h2C;
  localparam logic [7:0] OFS_MON_ADDR = 8'h30;
  localparam logic [7:0] OFS_MON_DATA = 8'h34;
  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int CTRL_EN      = 0;
  localparam int CTRL_TS      = 1;
  localparam int CTRL_RATE    = 2;
  localparam int CTRL_IRQ3    = 4;
  localparam int CTRL_RESTART = 5;
  localparam int STOP_EN      = 24;
  localparam logic [5:0] CTRL_RST = 6'h01;
  // ---------------------------------------------------------------
  // Sampled pin vector layout
  // ---------------------------------------------------------------
  localparam int P_ADDR  = 0;
  localparam int P_DATA  = 24;
  localparam int P_WR    = 40;
  localparam int P_WIDE  = 41;
  localparam int P_CYC   = 42;
  localparam int P_FETCH = 43;
  localparam int P_CPU   = 44;
  localparam int P_XFER  = 45;
  localparam int P_PROBE = 46;
  localparam int P_NMI   = 50;
  localparam int P_IRQ   = 51;
  localparam int P_RUN   = 59;
  localparam int PIN_W   = 60;
  // ---------------------------------------------------------------
  // Record layout and buffer
  // ---------------------------------------------------------------
  localparam int R_INFO  = 41;
  localparam int REC_W   = 63;
  localparam int DEPTH   = 256;
  localparam int TS_W    = 22;
  localparam logic [3:0] CNT_MAX = 4'h8;
  localparam logic [4:0] IRQ3_KEEP = 5'h00;
  // Time-stamp prescale terminal counts for rate select 0..3
  localparam logic [5:0] RATE0 = 6'h00;
  localparam logic [5:0] RATE1 = 6'h03;
  localparam logic [5:0] RATE2 = 6'h0F;
  localparam logic [5:0] RATE3 = 6'h3F;
  // ---------------------------------------------------------------
  // Area boundaries of the emulated map
  // ---------------------------------------------------------------
  localparam logic [23:0] ROM_END  = 24'h00FFFF;
  localparam logic [23:0] RAM_BEG  = 24'hFFE000;
  localparam logic [23:0] XRAM_BEG = 24'hFFEC00;
  localparam logic [23:0] XRAM_END = 24'hFFEFFF;
  localparam logic [23:0] RAM_END  = 24'hFFFEFF;
  localparam logic [23:0] IO_BEG   = 24'hFFFF00;
  typedef enum logic [1:0] {
    ST_PREFETCH = 2'b00, ST_DATA = 2'b01,
    ST_XFER = 2'b10, ST_OTHER = 2'b11
  } bctc_state_t;
  typedef enum logic [2:0] {
    AR_ROM = 3'b000, AR_RAM = 3'b001, AR_IO_WIDE = 3'b010,
    AR_IO_NARROW = 3'b011, AR_EXT_WIDE = 3'b100,
    AR_EXT_NARROW = 3'b101, AR_XRAM = 3'b110
  } bctc_area_t;
endpackage
`default_nettype wire

// ===== verilog/bctc_top.sv
`default_nettype none
module bctc_top (
  input  wire logic        REF_CLK,     // 25 MHz clock
  input  wire logic        RESETN,      // Async reset, active low
  input  wire logic        HSEL,        // AHB slave select
  input  wire logic [31:0] HADDR,       // AHB address
  input  wire logic [1:0]  HTRANS,      // AHB transfer type
  input  wire logic        HWRITE,      // AHB write
  input  wire logic [2:0]  HSIZE,       // AHB size (word only)
  input  wire logic [31:0] HWDATA,      // AHB write data
  input  wire logic        HREADY,      // AHB bus ready
  output logic      [31:0] HRDATA,      // AHB read data
  output logic             HREADYOUT,   // AHB slave ready
  output logic             HRESP,       // AHB response, always OKAY
  input  wire logic [23:0] TGT_ADDR,    // Target address bus
  input  wire logic [15:0] TGT_DATA,    // Target data bus
  input  wire logic        TGT_WRITE,   // Target cycle is a write
  input  wire logic        TGT_WIDE,    // Target cycle is 16 bits
  input  wire logic        TGT_CYC,     // High during a bus cycle
  input  wire logic        TGT_FETCH,   // CPU prefetch cycle
  input  wire logic        TGT_CPU,     // CPU data cycle
  input  wire logic        TGT_XFER,    // Transfer controller cycle
  input  wire logic [3:0]  TGT_PROBE,   // Probes 4..1
  input  wire logic        TGT_NMI,     // NMI pin level
  input  wire logic [7:0]  TGT_IRQ_N,   // IRQ7..0, low = asserted
  input  wire logic        TGT_RUN,     // High while program runs
  output logic             EVT_VALID,   // Pulse per finished cycle
  output logic      [1:0]  EVT_STATE,   // Bus state class
  output logic      [2:0]  EVT_AREA,    // Area class
  output logic             EVT_SUPPRESS,// Cycle dropped by suppress mask
  output logic             TRACE_FROZEN // Buffer frozen
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [bctc_pkg::PIN_W-1:0] pin1, pin2, samp;
    logic        cyc_q, run_q;
    logic [3:0]  clk_cnt;
    logic [5:0]  pre;
    logic [21:0] ts;
    logic [7:0]  wptr;
    logic        wrapped, enable, ts_mode, irq3;
    logic [1:0]  ts_rate;
    logic [3:0]  sup_mask;
    logic [23:0] stop_addr;
    logic        stop_en, stop_seen, frozen;
    logic [7:0]  delay, stop_ptr, delay_left, sel;
    logic [23:0] perf_lo, perf_hi;
    logic [3:0]  perf_mask;
    logic [31:0] perf_cnt;
    logic [23:0] mon_addr;
    logic [15:0] mon_data;
    logic        aw_pend;
    logic [7:0]  aw_ofs;
    logic [31:0] hrdata;
    logic        evt_valid, evt_sup;
    logic [1:0]  evt_state;
    logic [2:0]  evt_area;
  } bctc_regs_t;

  bctc_regs_t st_r, st_nxt;
  logic [bctc_pkg::REC_W-1:0] mem [bctc_pkg::DEPTH];
  logic                       mem_we;
  logic [7:0]                 mem_wa;
  logic [bctc_pkg::REC_W-1:0] mem_wd;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Priority: transfer controller owns the bus over the CPU
  function automatic logic [1:0] state_of(input logic fetch,
      input logic cpu, input logic xfer);
    if (xfer)
      return bctc_pkg::ST_XFER;
    else if (fetch)
      return bctc_pkg::ST_PREFETCH;
    else if (cpu)
      return bctc_pkg::ST_DATA;
    else
      return bctc_pkg::ST_OTHER;
  endfunction

  // Transfer RAM sits inside on-chip RAM, so it is tested before on-chip RAM
  function automatic logic [2:0] area_of(input logic [23:0] a,
      input logic wide);
    if (a >= bctc_pkg::IO_BEG)
      return wide ? bctc_pkg::AR_IO_WIDE : bctc_pkg::AR_IO_NARROW;
    else if (a >= bctc_pkg::XRAM_BEG && a <= bctc_pkg::XRAM_END)
      return bctc_pkg::AR_XRAM;
    else if (a >= bctc_pkg::RAM_BEG && a <= bctc_pkg::RAM_END)
      return bctc_pkg::AR_RAM;
    else if (a <= bctc_pkg::ROM_END)
      return bctc_pkg::AR_ROM;
    else
      return wide ? bctc_pkg::AR_EXT_WIDE : bctc_pkg::AR_EXT_NARROW;
  endfunction

  function automatic logic [5:0] rate_top(input logic [1:0] r);
    case (r)
      2'b00:   return bctc_pkg::RATE0;
      2'b01:   return bctc_pkg::RATE1;
      2'b10:   return bctc_pkg::RATE2;
      default: return bctc_pkg::RATE3;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [bctc_pkg::PIN_W-1:0] s;
    logic [1:0]  cst;
    logic [2:0]  car;
    logic [23:0] ca;
    logic [15:0] cd;
    logic        done, sup, rec, clock_count_overflow;
    logic [7:0]  irq, base, rptr;
    logic [21:0] info;
    logic [3:0]  cnt1;
    s = st_r.samp;
    st_nxt = st_r;
    mem_we = 1'b0;
    mem_wa = st_r.wptr;
    mem_wd = '0;
    // Pins come from the target's own clock: two flops first
    st_nxt.pin1 = {TGT_RUN, TGT_IRQ_N, TGT_NMI, TGT_PROBE, TGT_XFER,
                   TGT_CPU, TGT_FETCH, TGT_CYC, TGT_WIDE, TGT_WRITE,
                   TGT_DATA, TGT_ADDR};
    st_nxt.pin2 = st_r.pin1;
    st_nxt.cyc_q = st_r.pin2[bctc_pkg::P_CYC];
    st_nxt.run_q = st_r.pin2[bctc_pkg::P_RUN];
    // Count clocks of the cycle, saturating one past the maximum
    if (st_r.pin2[bctc_pkg::P_CYC]) begin
      st_nxt.samp = st_r.pin2;
      if (!st_r.cyc_q)
        st_nxt.clk_cnt = 4'h1;
      else if (st_r.clk_cnt <= bctc_pkg::CNT_MAX)
        st_nxt.clk_cnt = st_r.clk_cnt + 4'h1;
    end
    // Time stamp: prescaled tick, restarts on run start
    if (st_r.pre >= rate_top(st_r.ts_rate)) begin
      st_nxt.pre = 6'h00;
      st_nxt.ts = st_r.ts + 22'h000001;
    end else begin
      st_nxt.pre = st_r.pre + 6'h01;
    end
    if (st_r.pin2[bctc_pkg::P_RUN] && !st_r.run_q) begin
      st_nxt.pre = 6'h00;
      st_nxt.ts = '0;
    end
    // Classify the cycle that just ended (falling cycle strobe)
    done = st_r.cyc_q && !st_r.pin2[bctc_pkg::P_CYC];
    cst = state_of(s[bctc_pkg::P_FETCH], s[bctc_pkg::P_CPU],
                   s[bctc_pkg::P_XFER]);
    ca = s[bctc_pkg::P_ADDR +: 24];
    car = area_of(ca, s[bctc_pkg::P_WIDE]);
    cd = s[bctc_pkg::P_DATA +: 16];
    if (!s[bctc_pkg::P_WIDE])
      cd = {8'h00, cd[7:0]};
    sup = st_r.sup_mask[cst];
    rec = done && !sup && st_r.enable && !st_r.frozen;
    clock_count_overflow = st_r.clk_cnt > bctc_pkg::CNT_MAX;
    cnt1 = st_r.clk_cnt - 4'h1;
    irq = s[bctc_pkg::P_IRQ +: 8];
    if (st_r.irq3)
      irq = {bctc_pkg::IRQ3_KEEP, irq[2:0]};
    info = {irq, s[bctc_pkg::P_NMI], s[bctc_pkg::P_PROBE +: 4],
            clock_count_overflow, (clock_count_overflow ? 3'h7 : cnt1[2:0]), cst, car};
    if (st_r.ts_mode)
      info = st_r.ts;
    // Event outputs for comparators and counters
    st_nxt.evt_valid = done;
    st_nxt.evt_state = cst;
    st_nxt.evt_area = car;
    st_nxt.evt_sup = done && sup;
    if (done && st_r.perf_mask[cst] && ca >= st_r.perf_lo &&
        ca <= st_r.perf_hi)
      st_nxt.perf_cnt = st_r.perf_cnt + 32'h1;
    // Shadow a watched location from observed traffic only
    if (done && ca == st_r.mon_addr)
      st_nxt.mon_data = cd;
    // Circular recording with stop point and delay
    if (rec) begin
      mem_we = 1'b1;
      mem_wd = {info, s[bctc_pkg::P_WR], cd, ca};
      st_nxt.wptr = st_r.wptr + 8'h01;
      if (st_r.wptr == 8'hFF)
        st_nxt.wrapped = 1'b1;
      if (st_r.stop_seen) begin
        st_nxt.delay_left = st_r.delay_left - 8'h01;
        if (st_r.delay_left == 8'h01)
          st_nxt.frozen = 1'b1;
      end else if (st_r.stop_en && ca == st_r.stop_addr) begin
        st_nxt.stop_seen = 1'b1;
        st_nxt.stop_ptr = st_r.wptr;
        st_nxt.delay_left = st_r.delay;
        if (st_r.delay == 8'h00)
          st_nxt.frozen = 1'b1;
      end
    end
    // Relative index: base is the stop cycle or the newest record
    base = st_r.stop_seen ? st_r.stop_ptr : st_r.wptr - 8'h01;
    rptr = base + st_r.sel;
    // AHB data phase of a write
    if (st_r.aw_pend) begin
      case (st_r.aw_ofs)
        bctc_pkg::OFS_CTRL: begin
          st_nxt.enable = HWDATA[bctc_pkg::CTRL_EN];
          st_nxt.ts_mode = HWDATA[bctc_pkg::CTRL_TS];
          st_nxt.ts_rate = HWDATA[bctc_pkg::CTRL_RATE +: 2];
          st_nxt.irq3 = HWDATA[bctc_pkg::CTRL_IRQ3];
          if (HWDATA[bctc_pkg::CTRL_RESTART]) begin
            st_nxt.wptr = 8'h00;
            st_nxt.wrapped = 1'b0;
            st_nxt.stop_seen = 1'b0;
            st_nxt.frozen = 1'b0;
            mem_we = 1'b0;
          end
        end
        bctc_pkg::OFS_SUPPRESS: st_nxt.sup_mask = HWDATA[3:0];
        bctc_pkg::OFS_STOP: begin
          st_nxt.stop_addr = HWDATA[23:0];
          st_nxt.stop_en = HWDATA[bctc_pkg::STOP_EN];
        end
        bctc_pkg::OFS_DELAY:    st_nxt.delay = HWDATA[7:0];
        bctc_pkg::OFS_SEL:      st_nxt.sel = HWDATA[7:0];
        bctc_pkg::OFS_PERF_LO:  st_nxt.perf_lo = HWDATA[23:0];
        bctc_pkg::OFS_PERF_HI:  st_nxt.perf_hi = HWDATA[23:0];
        bctc_pkg::OFS_PERF_SEL: st_nxt.perf_mask = HWDATA[3:0];
        bctc_pkg::OFS_PERF_CNT: st_nxt.perf_cnt = 32'h0;
        bctc_pkg::OFS_MON_ADDR: st_nxt.mon_addr = HWDATA[23:0];
        default: ;
      endcase
    end
    // AHB address phase: reads answer with zero wait states
    st_nxt.aw_pend = 1'b0;
    if (HSEL && HTRANS[1] && HREADY) begin
      st_nxt.aw_pend = HWRITE;
      st_nxt.aw_ofs = {HADDR[7:2], 2'b00};
      st_nxt.hrdata = 32'h0;
      if (!HWRITE) begin
        case ({HADDR[7:2], 2'b00})
          bctc_pkg::OFS_CTRL:
            st_nxt.hrdata = {27'h0, st_r.irq3, st_r.ts_rate,
                             st_r.ts_mode, st_r.enable};
          bctc_pkg::OFS_SUPPRESS:
            st_nxt.hrdata = {28'h0, st_r.sup_mask};
          bctc_pkg::OFS_STOP:
            st_nxt.hrdata = {7'h0, st_r.stop_en, st_r.stop_addr};
          bctc_pkg::OFS_DELAY:
            st_nxt.hrdata = {24'h0, st_r.delay};
          bctc_pkg::OFS_STATUS:
            st_nxt.hrdata = {st_r.stop_ptr, st_r.delay_left, st_r.wptr,
                             5'h0, st_r.wrapped, st_r.stop_seen,
                             st_r.frozen};
          bctc_pkg::OFS_SEL:
            st_nxt.hrdata = {24'h0, st_r.sel};
          bctc_pkg::OFS_REC_LO:
            st_nxt.hrdata = mem[rptr][31:0];
          bctc_pkg::OFS_REC_HI:
            st_nxt.hrdata = {1'b0, mem[rptr][62:32]};
          bctc_pkg::OFS_PERF_LO:
            st_nxt.hrdata = {8'h0, st_r.perf_lo};
          bctc_pkg::OFS_PERF_HI:
            st_nxt.hrdata = {8'h0, st_r.perf_hi};
          bctc_pkg::OFS_PERF_SEL:
            st_nxt.hrdata = {28'h0, st_r.perf_mask};
          bctc_pkg::OFS_PERF_CNT:
            st_nxt.hrdata = st_r.perf_cnt;
          bctc_pkg::OFS_MON_ADDR:
            st_nxt.hrdata = {8'h0, st_r.mon_addr};
          bctc_pkg::OFS_MON_DATA:
            st_nxt.hrdata = {16'h0, st_r.mon_data};
          default: st_nxt.hrdata = 32'h0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r <= '0;
      st_r.enable <= bctc_pkg::CTRL_RST[bctc_pkg::CTRL_EN];
      st_r.pin1 <= '1;
      st_r.pin2 <= '1;
      st_r.pin1[bctc_pkg::P_CYC] <= 1'b0;
      st_r.pin2[bctc_pkg::P_CYC] <= 1'b0;
      st_r.pin1[bctc_pkg::P_RUN] <= 1'b0;
      st_r.pin2[bctc_pkg::P_RUN] <= 1'b0;
      st_r.perf_hi <= 24'hFFFFFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Trace memory has no reset; reads are not limited to written records
  always_ff @(posedge REF_CLK) begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign HRDATA = st_r.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign EVT_VALID = st_r.evt_valid;
  assign EVT_STATE = st_r.evt_state;
  assign EVT_AREA = st_r.evt_area;
  assign EVT_SUPPRESS = st_r.evt_sup;
  assign TRACE_FROZEN = st_r.frozen;
endmodule // bctc_top
`default_nettype wire

// ===== testbench/bctc_assertions.sv
`default_nettype none
module bctc_checker (
  input  wire logic        REF_CLK,      // Clock
  input  wire logic        RESETN,       // Reset, active low
  input  wire logic [1:0]  HTRANS,       // Transfer type
  input  wire logic        HREADYOUT,    // Slave ready
  input  wire logic        HRESP,        // Slave response
  input  wire logic [23:0] TGT_ADDR,     // Target address
  input  wire logic        TGT_WIDE,     // 16-bit cycle
  input  wire logic        TGT_CYC,      // Cycle strobe
  input  wire logic        TGT_FETCH,    // Prefetch class
  input  wire logic        TGT_XFER,     // Transfer class
  input  wire logic        EVT_VALID,    // Cycle ended
  input  wire logic [1:0]  EVT_STATE,    // State class
  input  wire logic [2:0]  EVT_AREA,     // Area class
  input  wire logic        EVT_SUPPRESS, // Cycle dropped by suppress mask
  input  wire logic        TRACE_FROZEN  // Buffer frozen
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Port checks, all in the one clock domain
  // ---------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // Host side never stalls, so monitoring cannot hold the target
  a_bus_ready: assert property (HREADYOUT && !HRESP)
    else $error("host slave stalled or not okay");
  // Event comes exactly three clocks after the strobe falls
  a_evt_delay: assert property ($fell(TGT_CYC) |->
    !EVT_VALID[*3] ##1 EVT_VALID)
    else $error("cycle event late or early");
  a_evt_source: assert property (EVT_VALID |->
    $past(TGT_CYC, 4) && !$past(TGT_CYC, 3))
    else $error("event without an ended cycle");
  a_evt_pulse: assert property (EVT_VALID |=> !EVT_VALID)
    else $error("event wider than one clock");
  // Class lines seen on the last high clock decide the state
  a_state_fetch: assert property ($fell(TGT_CYC) && $past(TGT_FETCH)
    |-> ##3 EVT_STATE == bctc_pkg::ST_PREFETCH)
    else $error("prefetch cycle misclassified");
  a_state_xfer: assert property ($fell(TGT_CYC) && $past(TGT_XFER)
    |-> ##3 EVT_STATE == bctc_pkg::ST_XFER)
    else $error("transfer cycle misclassified");
  a_area_rom: assert property ($fell(TGT_CYC) &&
    $past(TGT_ADDR) <= bctc_pkg::ROM_END |-> ##3 EVT_AREA == bctc_pkg::AR_ROM)
    else $error("rom area misclassified");
  a_area_io: assert property ($fell(TGT_CYC) &&
    $past(TGT_ADDR) >= bctc_pkg::IO_BEG |-> ##3 EVT_AREA ==
    ($past(TGT_WIDE, 4) ? bctc_pkg::AR_IO_WIDE : bctc_pkg::AR_IO_NARROW))
    else $error("io area misclassified");
  a_sup_valid: assert property (EVT_SUPPRESS |-> EVT_VALID)
    else $error("suppress flag outside an event");
  // Only a host write may thaw the buffer
  a_frozen_hold: assert property (TRACE_FROZEN && !HTRANS[1] &&
    !$past(HTRANS[1]) && !$past(HTRANS[1], 2) |=> TRACE_FROZEN)
    else $error("frozen buffer thawed by itself");
endmodule // bctc_checker

bind bctc_top bctc_checker u_chk (.REF_CLK, .RESETN, .HTRANS, .HREADYOUT,
  .HRESP, .TGT_ADDR, .TGT_WIDE, .TGT_CYC, .TGT_FETCH, .TGT_XFER,
  .EVT_VALID, .EVT_STATE, .EVT_AREA, .EVT_SUPPRESS, .TRACE_FROZEN);
`default_nettype wire

// ===== testbench/bctc_tgt_model.sv
`default_nettype none
module bctc_tgt_model (
  input  wire logic        REF_CLK,   // Target bus clock
  output logic      [23:0] TGT_ADDR,  // Address bus
  output logic      [15:0] TGT_DATA,  // Data bus
  output logic             TGT_WRITE, // Write cycle
  output logic             TGT_WIDE,  // 16-bit cycle
  output logic             TGT_CYC,   // Cycle strobe
  output logic             TGT_FETCH, // Prefetch class
  output logic             TGT_CPU,   // Data class
  output logic             TGT_XFER,  // Transfer class
  output logic             TGT_RUN    // Program running
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {TGT_ADDR, TGT_DATA, TGT_WRITE, TGT_WIDE} = '0;
    {TGT_CYC, TGT_FETCH, TGT_CPU, TGT_XFER, TGT_RUN} = '0;
  end
  // ---------------------------------------------------------------
  // One bus cycle: n clocks high, six low
  // ---------------------------------------------------------------
  // Released lines are inverted so stale values never look valid
  task automatic cyc_run(input logic [23:0] a, input logic [15:0] d,
                         input logic w, wd, input logic [2:0] c,
                         input int n);
    @(posedge REF_CLK);
    {TGT_ADDR, TGT_DATA, TGT_WRITE, TGT_WIDE} <= {a, d, w, wd};
    {TGT_XFER, TGT_CPU, TGT_FETCH, TGT_CYC} <= {c, 1'b1};
    repeat (n) @(posedge REF_CLK);
    {TGT_ADDR, TGT_DATA, TGT_CYC} <= {~a, ~d, 1'b0};
    repeat (5) @(posedge REF_CLK);
  endtask
  task automatic set_run(input logic v);
    @(posedge REF_CLK);
    TGT_RUN <= v;
  endtask
endmodule // bctc_tgt_model
`default_nettype wire

// ===== testbench/bctc_bench.sv
`default_nettype none
module bctc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK = 1'b0, RESETN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic        HREADYOUT, HRESP, EVT_VALID, EVT_SUPPRESS, TRACE_FROZEN;
  logic        TGT_NMI = 1'b1;
  logic [1:0]  HTRANS = '0, EVT_STATE;
  logic [2:0]  EVT_AREA;
  logic [3:0]  TGT_PROBE = 4'hA;
  logic [7:0]  TGT_IRQ_N = 8'h5A;
  logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, rd;
  logic [62:0] r, p;
  logic [23:0] a;
  logic [15:0] d;
  logic [5:0]  ev;
  int          num_errors = 0, tests_run = 0;
  wire logic [23:0] TGT_ADDR;
  wire logic [15:0] TGT_DATA;
  wire logic TGT_WRITE, TGT_WIDE, TGT_CYC, TGT_FETCH, TGT_CPU, TGT_XFER;
  wire logic TGT_RUN;
  bctc_top dut (.REF_CLK, .RESETN, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT,
    .HRESP, .TGT_ADDR, .TGT_DATA, .TGT_WRITE, .TGT_WIDE, .TGT_CYC,
    .TGT_FETCH, .TGT_CPU, .TGT_XFER, .TGT_PROBE, .TGT_NMI, .TGT_IRQ_N,
    .TGT_RUN, .EVT_VALID, .EVT_STATE, .EVT_AREA, .EVT_SUPPRESS,
    .TRACE_FROZEN);
  bctc_tgt_model u_tgt (.REF_CLK, .TGT_ADDR, .TGT_DATA, .TGT_WRITE,
    .TGT_WIDE, .TGT_CYC, .TGT_FETCH, .TGT_CPU, .TGT_XFER, .TGT_RUN);
  always #20 REF_CLK = ~REF_CLK;
  // Keep the classes of the last event for later comparison
  always @(posedge REF_CLK) begin
    if (EVT_VALID === 1'b1) ev <= {EVT_SUPPRESS, EVT_STATE, EVT_AREA};
  end
  // ---------------------------------------------------------------
  // Host bus, target cycles and comparison
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("mismatches %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [62:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Single word transfer; waits on ready in both phases
  task automatic ahb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h0, ad};
    HWRITE <= w;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  task automatic rdc(input string n, input logic [7:0] ad,
                     input logic [31:0] e);
    ahb(1'b0, ad, 32'h0);
    chk(n, 63'(e), 63'(rd));
  endtask
  task automatic rec(input logic [7:0] s);
    ahb(1'b1, bctc_pkg::OFS_SEL, {24'h0, s});
    ahb(1'b0, bctc_pkg::OFS_REC_LO, 32'h0);
    r[31:0] = rd;
    ahb(1'b0, bctc_pkg::OFS_REC_HI, 32'h0);
    r[62:32] = rd[30:0];
  endtask
  task automatic cy(input logic [1:0] s, input int n);
    u_tgt.cyc_run(a, d, 1'b0, 1'b1, s == 2'd3 ? 3'b000 : 3'b001 << s, n);
  endtask
  // Narrow cycles carry a zero upper data byte
  function automatic logic [62:0] mk(input logic w, wd,
      input logic [1:0] s, input logic [2:0] ar, c);
    return {TGT_IRQ_N, TGT_NMI, TGT_PROBE, 1'b0, c, s, ar, w,
            wd ? d : {8'h00, d[7:0]}, a};
  endfunction
  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge REF_CLK);
    RESETN <= 1'b1;
    rdc("ctrl", bctc_pkg::OFS_CTRL, 32'h1);
    rdc("unmapped", 8'h3C, 32'h0);
    $display("test reset done");
    // One cycle per area, states and widths rotating
    for (int i = 0; i < 7; i++) begin
      a = (i < 2) ? (i == 0 ? 24'h000100 : 24'hFFE100) :
          (i < 4) ? 24'hFFFF10 : (i < 6) ? 24'h300000 : 24'hFFED00;
      d = 16'hC35A + 16'(i);
      u_tgt.cyc_run(a, d, i[1], !i[0], i[1:0] == 2'd3 ? 3'b000 :
                    3'b001 << i[1:0], i + 2);
      p = r;
      rec(8'h00);
      chk("record", mk(i[1], !i[0], i[1:0], 3'(i), 3'(i + 1)), r);
      chk("event", {57'h0, 1'b0, i[1:0], 3'(i)}, 63'(ev));
    end
    rec(8'hFF);
    chk("older", p, r);
    a = 24'h000200;
    cy(2'd0, 9);
    rec(8'h00);
    chk("overflow", 63'h1, 63'(r[49]));
    $display("test capture done");
    ahb(1'b1, bctc_pkg::OFS_CTRL, 32'h11);
    TGT_IRQ_N <= 8'hFD;
    TGT_NMI <= 1'b0;
    cy(2'd1, 2);
    rec(8'h00);
    chk("irq3", mk(1'b0, 1'b1, 2'd1, 3'd0, 3'd1) & 63'h03FFFFFFFFFFFFFF, r);
    ahb(1'b1, bctc_pkg::OFS_CTRL, 32'h1);
    ahb(1'b1, bctc_pkg::OFS_SUPPRESS, 32'h2);
    p = r;
    cy(2'd1, 2);
    chk("sup_flag", 63'h1, 63'(ev[5]));
    rec(8'h00);
    chk("sup_keep", p, r);
    ahb(1'b1, bctc_pkg::OFS_SUPPRESS, 32'h0);
    ahb(1'b1, bctc_pkg::OFS_PERF_SEL, 32'h1);
    ahb(1'b1, bctc_pkg::OFS_PERF_CNT, 32'h0);
    cy(2'd0, 2);
    cy(2'd1, 2);
    cy(2'd0, 3);
    rdc("perf", bctc_pkg::OFS_PERF_CNT, 32'h2);
    ahb(1'b1, bctc_pkg::OFS_MON_ADDR, 32'hFFE200);
    a = 24'hFFE200;
    d = 16'hBEEF;
    u_tgt.cyc_run(a, d, 1'b1, 1'b1, 3'b010, 3);
    rdc("monitor", bctc_pkg::OFS_MON_DATA, 32'hBEEF);
    $display("test qualifiers done");
    // Cycles eight clocks apart give exact stamp differences
    for (int k = 0; k < 2; k++) begin
      ahb(1'b1, bctc_pkg::OFS_CTRL, k == 0 ? 32'h3 : 32'h7);
      u_tgt.set_run(1'b0);
      u_tgt.set_run(1'b1);
      cy(2'd0, 2);
      cy(2'd0, 2);
      rec(8'hFF);
      p = r;
      chk("ts_clear", 63'h1, 63'(p[62:41] < 22'd40));
      rec(8'h00);
      chk("ts_step", k == 0 ? 63'd8 : 63'd2, 63'(r[62:41] - p[62:41]));
      chk("ts_addr", 63'(a), 63'(r[23:0]));
    end
    $display("test time stamp done");
    ahb(1'b1, bctc_pkg::OFS_CTRL, 32'h21);
    ahb(1'b1, bctc_pkg::OFS_STOP, 32'h010000AA);
    ahb(1'b1, bctc_pkg::OFS_DELAY, 32'h2);
    for (int i = 0; i < 6; i++) begin
      a = (i == 2) ? 24'h0000AA : 24'(i * 16 + 16);
      cy(2'd0, 2);
    end
    chk("frozen", 63'h1, 63'(TRACE_FROZEN));
    for (int i = 0; i < 4; i++) begin
      rec(i == 3 ? 8'hFF : 8'(i));
      a = (i == 0) ? 24'hAA : (i == 3) ? 24'h20 : 24'(i * 16 + 48);
      chk("stop_index", 63'(a), 63'(r[23:0]));
    end
    rdc("status", bctc_pkg::OFS_STATUS, 32'h02000503);
    $display("test stop done");
    complete_run();
  end
  // Whole run needs well under a thousand clocks; this is far beyond
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
endmodule // bctc_bench
`default_nettype wire
